// ### pkg/eirq_pkg.sv
package eirq_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [15:0] IDX_P2_DATA  = 16'hfe48;
    localparam logic [15:0] IDX_P2_DIR   = 16'hfe49;
    localparam logic [15:0] IDX_SEL_CTRL = 16'hfe4a;
    localparam logic [15:0] IDX_ROUTING  = 16'hfe4b;
    localparam logic [15:0] IDX_FIXED    = 16'hfe4e;
    localparam logic [31:0] ADDR_P2_DATA  = {14'h0000, IDX_P2_DATA, 2'h0};
    localparam logic [31:0] ADDR_P2_DIR   = {14'h0000, IDX_P2_DIR, 2'h0};
    localparam logic [31:0] ADDR_SEL_CTRL = {14'h0000, IDX_SEL_CTRL, 2'h0};
    localparam logic [31:0] ADDR_ROUTING  = {14'h0000, IDX_ROUTING, 2'h0};
    localparam logic [31:0] ADDR_FIXED    = {14'h0000, IDX_FIXED, 2'h0};
    localparam logic [7:0]  REG_RESET     = 8'h00;

    // Control register layout, shared by the selectable and the fixed pair.
    localparam int B_LO_EN   = 0;
    localparam int B_LO_FLAG = 1;
    localparam int B_LO_FALL = 2;
    localparam int B_LO_RISE = 3;
    localparam int B_HI_EN   = 4;
    localparam int B_HI_FLAG = 5;
    localparam int B_HI_FALL = 6;
    localparam int B_HI_RISE = 7;

    // Routing register layout.
    localparam int R_LO_FUNC = 0;
    localparam int R_LO_PIN  = 2;
    localparam int R_HI_FUNC = 4;
    localparam int R_HI_PIN  = 6;

    // Pin positions on the port-two input vector.
    localparam logic       HI_PIN_BASE  = 1'b1;
    localparam int         PIN_SIXTH    = 0;
    localparam int         PIN_SEVENTH  = 4;

    // Extra function codes of a selectable interrupt.
    localparam logic [1:0] FUNC_NONE   = 2'h0;
    localparam logic [1:0] FUNC_COUNT  = 2'h1;
    localparam logic [1:0] FUNC_CAP_LO = 2'h2;
    localparam logic [1:0] FUNC_CAP_HI = 2'h3;

    // Interrupt vectors of the four requests.
    localparam logic [15:0] VEC_LOW_SEL  = 16'h0013;
    localparam logic [15:0] VEC_HIGH_SEL = 16'h001b;
    localparam logic [15:0] VEC_SIXTH    = 16'h0023;
    localparam logic [15:0] VEC_SEVENTH  = 16'h002b;

    // Free-running count period in instruction cycles.
    localparam int TCYC_PER_COUNT = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LP_RUN  = 2'b00,
        LP_HALT = 2'b01,
        LP_HOLD = 2'b10
    } eirq_lp_t;
endpackage

// ### rtl/eirq_router.sv
// Operation
// - High interrupt function bits pick timer role.
// - Low interrupt pin from four port-two pins.
// - Low interrupt function bits pick timer role.
// - Configured edge raises the selected timer pulse.
// - Port-seven capture ignored when selectable drives it.
// - Both selectable events same cycle count once.
// - Event count if selected, else every 2 Tcyc.
// - Seventh interrupt edge mode on fifth pin.
// - Seventh edge makes high-half secondary capture.
// - Seventh flag sets, cleared only by software.
// - Seventh request while flag and enable set.
// - Sixth interrupt edge mode on first pin.
// - Sixth edge makes low-half secondary capture.
// - Sixth flag sets, cleared only by software.
// - Sixth request while flag and enable set.
// - Port-two pins frozen during halt or hold.
// - High interrupt pin from four candidates.
// - Selectable edge modes and sticky flags.
// - Selectable flag and enable request and release.
// - In hold, no selectable edge toward entry level.
`timescale 1ns/1ps
module eirq_router #(
    parameter int CLKS_PER_TCYC = 3
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  port_two_in,
    output logic [7:0]       port_two_out,
    output logic [7:0]       port_two_oe_n,
    input  wire logic        halt_mode,
    input  wire logic        hold_mode,
    input  wire logic        port_seven_cap_lo,
    input  wire logic        port_seven_cap_hi,
    output logic             irq_req_low_sel,
    output logic             irq_req_high_sel,
    output logic             irq_req_sixth,
    output logic             irq_req_seventh,
    output logic             hold_release,
    output logic             second_timer_low_count,
    output logic             second_timer_low_event_mode,
    output logic             first_timer_low_capture,
    output logic             first_timer_high_capture,
    output logic             first_timer_low_capture1,
    output logic             first_timer_high_capture1
);
    localparam int DIV_CLKS = eirq_pkg::TCYC_PER_COUNT * CLKS_PER_TCYC;
    localparam int DIV_W    = $clog2(DIV_CLKS + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CLKS - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    // The divider must have at least one clock per instruction cycle.
    if (CLKS_PER_TCYC < 1) begin : g_bad_tcyc
        $error("CLKS_PER_TCYC must be at least 1");
    end

    typedef struct packed {
        logic [7:0]         sel_ctrl;
        logic [7:0]         routing;
        logic [7:0]         fixed_ctrl;
        logic [7:0]         p2_data;
        logic [7:0]         p2_dir;
        logic [7:0]         p2_out;
        logic [7:0]         p2_oe_n;
        logic [7:0]         pin_cur;
        logic [7:0]         pin_prv;
        eirq_pkg::eirq_lp_t lp;
        logic [1:0]         entry_lvl;
        logic [DIV_W-1:0]   div;
        logic               cnt_pulse;
        logic               cap_lo;
        logic               cap_hi;
        logic               cap1_lo;
        logic               cap1_hi;
        logic               aw_have;
        logic [31:0]        awaddr;
        logic               w_have;
        logic [7:0]         wdata;
        logic               wstrb0;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [7:0]         rdata;
        logic [1:0]         rresp;
    } eirq_state_t;

    eirq_state_t s;
    eirq_state_t next_s;

    logic [3:0] lvl_now;
    logic [3:0] lvl_prv;
    logic [3:0] rise_en;
    logic [3:0] fall_en;
    logic [3:0] blk_rise;
    logic [3:0] blk_fall;
    logic [3:0] ev;
    logic [2:0] lo_pin;
    logic [2:0] hi_pin;
    logic [1:0] lo_func;
    logic [1:0] hi_func;
    logic       in_hold;

    // Pin choice for the selectable pair.
    assign lo_pin  = {1'b0, s.routing[eirq_pkg::R_LO_PIN +: 2]};
    assign hi_pin  = {eirq_pkg::HI_PIN_BASE, s.routing[eirq_pkg::R_HI_PIN +: 2]};
    assign lo_func = s.routing[eirq_pkg::R_LO_FUNC +: 2];
    assign hi_func = s.routing[eirq_pkg::R_HI_FUNC +: 2];
    assign in_hold = (s.lp == eirq_pkg::LP_HOLD);

    // Sources 0..3 are low selectable, high selectable, sixth and seventh.
    assign lvl_now = {s.pin_cur[eirq_pkg::PIN_SEVENTH], s.pin_cur[eirq_pkg::PIN_SIXTH],
                      s.pin_cur[hi_pin], s.pin_cur[lo_pin]};
    assign lvl_prv = {s.pin_prv[eirq_pkg::PIN_SEVENTH], s.pin_prv[eirq_pkg::PIN_SIXTH],
                      s.pin_prv[hi_pin], s.pin_prv[lo_pin]};
    assign rise_en = {s.fixed_ctrl[eirq_pkg::B_HI_RISE], s.fixed_ctrl[eirq_pkg::B_LO_RISE],
                      s.sel_ctrl[eirq_pkg::B_HI_RISE], s.sel_ctrl[eirq_pkg::B_LO_RISE]};
    assign fall_en = {s.fixed_ctrl[eirq_pkg::B_HI_FALL], s.fixed_ctrl[eirq_pkg::B_LO_FALL],
                      s.sel_ctrl[eirq_pkg::B_HI_FALL], s.sel_ctrl[eirq_pkg::B_LO_FALL]};

    // In hold, a selectable-pair edge toward the level held at entry cannot set a flag.
    assign blk_rise = {2'b00, in_hold & s.entry_lvl[1], in_hold & s.entry_lvl[0]};
    assign blk_fall = {2'b00, in_hold & ~s.entry_lvl[1], in_hold & ~s.entry_lvl[0]};

    // One edge detector per source, comparing two successive samples.
    for (genvar i = 0; i < 4; i++) begin : g_edge
        assign ev[i] = (rise_en[i] & ~blk_rise[i] & lvl_now[i] & ~lvl_prv[i]) |
                       (fall_en[i] & ~blk_fall[i] & ~lvl_now[i] & lvl_prv[i]);
    end

    // Register flags merge a detected edge with a software write; the edge wins.
    function automatic logic [7:0] merge_ctrl(input logic [7:0] cur, input logic wr,
                                              input logic [7:0] wd, input logic ev_lo,
                                              input logic ev_hi);
        logic [7:0] v;
        v = wr ? wd : cur;
        v[eirq_pkg::B_LO_FLAG] = v[eirq_pkg::B_LO_FLAG] | ev_lo;
        v[eirq_pkg::B_HI_FLAG] = v[eirq_pkg::B_HI_FLAG] | ev_hi;
        return v;
    endfunction

    // Next-state logic for the whole block.
    always_comb begin
        logic       wr_fire;
        logic       wr_ok;
        logic       use_count;
        logic       own_cap_lo;
        logic       own_cap_hi;
        logic [7:0] rd;
        logic       rd_ok;
        wr_fire    = s.aw_have & s.w_have & ~s.bvalid;
        wr_ok      = 1'b0;
        rd         = eirq_pkg::REG_RESET;
        rd_ok      = 1'b1;
        use_count  = (lo_func == eirq_pkg::FUNC_COUNT) | (hi_func == eirq_pkg::FUNC_COUNT);
        own_cap_lo = (lo_func == eirq_pkg::FUNC_CAP_LO) | (hi_func == eirq_pkg::FUNC_CAP_LO);
        own_cap_hi = (lo_func == eirq_pkg::FUNC_CAP_HI) | (hi_func == eirq_pkg::FUNC_CAP_HI);
        next_s     = s;

        next_s.pin_cur = port_two_in;
        next_s.pin_prv = s.pin_cur;

        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_have = 1'b1;
            next_s.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_have = 1'b1;
            next_s.wdata  = s_axi_wdata[7:0];
            next_s.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
            next_s.bvalid  = 1'b1;
            wr_ok = (s.awaddr == eirq_pkg::ADDR_P2_DATA) | (s.awaddr == eirq_pkg::ADDR_P2_DIR) |
                    (s.awaddr == eirq_pkg::ADDR_SEL_CTRL) | (s.awaddr == eirq_pkg::ADDR_ROUTING) |
                    (s.awaddr == eirq_pkg::ADDR_FIXED);
            next_s.bresp = wr_ok ? eirq_pkg::RESP_OKAY : eirq_pkg::RESP_SLVERR;
            if (s.wstrb0 && s.awaddr == eirq_pkg::ADDR_ROUTING) begin
                next_s.routing = s.wdata;
            end
            if (s.wstrb0 && s.awaddr == eirq_pkg::ADDR_P2_DATA) begin
                next_s.p2_data = s.wdata;
            end
            if (s.wstrb0 && s.awaddr == eirq_pkg::ADDR_P2_DIR) begin
                next_s.p2_dir = s.wdata;
            end
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        next_s.sel_ctrl = merge_ctrl(s.sel_ctrl, wr_fire & s.wstrb0 &
                                     (s.awaddr == eirq_pkg::ADDR_SEL_CTRL),
                                     s.wdata, ev[0], ev[1]);
        next_s.fixed_ctrl = merge_ctrl(s.fixed_ctrl, wr_fire & s.wstrb0 &
                                       (s.awaddr == eirq_pkg::ADDR_FIXED),
                                       s.wdata, ev[2], ev[3]);

        // Read channel: decoded on the address handshake, answered next cycle.
        case (s_axi_araddr)
            eirq_pkg::ADDR_P2_DATA:  rd = s.pin_cur;
            eirq_pkg::ADDR_P2_DIR:   rd = s.p2_dir;
            eirq_pkg::ADDR_SEL_CTRL: rd = s.sel_ctrl;
            eirq_pkg::ADDR_ROUTING:  rd = s.routing;
            eirq_pkg::ADDR_FIXED:    rd = s.fixed_ctrl;
            default:                 rd_ok = 1'b0;
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd;
            next_s.rresp  = rd_ok ? eirq_pkg::RESP_OKAY : eirq_pkg::RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // Low-power tracking; entry levels are caught on the way into hold.
        next_s.lp = hold_mode ? eirq_pkg::LP_HOLD : (halt_mode ? eirq_pkg::LP_HALT : eirq_pkg::LP_RUN);
        case (s.lp)
            eirq_pkg::LP_RUN, eirq_pkg::LP_HALT: begin
                if (hold_mode) begin
                    next_s.entry_lvl = lvl_now[1:0];
                end
            end
            eirq_pkg::LP_HOLD: begin
                next_s.entry_lvl = s.entry_lvl;
            end
            default: begin
                next_s.lp = eirq_pkg::LP_RUN;
            end
        endcase

        // Port-two drive follows its registers only outside halt and hold.
        if (next_s.lp == eirq_pkg::LP_RUN && s.lp == eirq_pkg::LP_RUN) begin
            next_s.p2_out  = s.p2_data;
            next_s.p2_oe_n = ~s.p2_dir;
        end

        // Timer pulses; OR-ing the two sources merges a coincident pair into one.
        if (use_count) begin
            next_s.div       = DIV_ZERO;
            next_s.cnt_pulse = (ev[0] & (lo_func == eirq_pkg::FUNC_COUNT)) |
                               (ev[1] & (hi_func == eirq_pkg::FUNC_COUNT));
        end else begin
            next_s.div       = (s.div == DIV_LAST) ? DIV_ZERO : s.div + 1'b1;
            next_s.cnt_pulse = (s.div == DIV_LAST);
        end
        next_s.cap_lo = (ev[0] & (lo_func == eirq_pkg::FUNC_CAP_LO)) |
                        (ev[1] & (hi_func == eirq_pkg::FUNC_CAP_LO)) |
                        (port_seven_cap_lo & ~own_cap_lo);
        next_s.cap_hi = (ev[0] & (lo_func == eirq_pkg::FUNC_CAP_HI)) |
                        (ev[1] & (hi_func == eirq_pkg::FUNC_CAP_HI)) |
                        (port_seven_cap_hi & ~own_cap_hi);
        next_s.cap1_lo = ev[2];
        next_s.cap1_hi = ev[3];
    end

    // Single state register of the block.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s            <= '0;
            s.sel_ctrl   <= eirq_pkg::REG_RESET;
            s.routing    <= eirq_pkg::REG_RESET;
            s.fixed_ctrl <= eirq_pkg::REG_RESET;
            s.p2_oe_n    <= 8'hff;
            s.lp         <= eirq_pkg::LP_RUN;
        end else begin
            s <= next_s;
        end
    end

    // Bus handshakes; one write and one read are held at a time.
    assign s_axi_awready = ~s.aw_have & ~s.bvalid;
    assign s_axi_wready  = ~s.w_have & ~s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = {24'h000000, s.rdata};
    assign s_axi_rresp   = s.rresp;

    // Requests are levels decoded from the registered flags and enables.
    assign irq_req_low_sel  = s.sel_ctrl[eirq_pkg::B_LO_FLAG] & s.sel_ctrl[eirq_pkg::B_LO_EN];
    assign irq_req_high_sel = s.sel_ctrl[eirq_pkg::B_HI_FLAG] & s.sel_ctrl[eirq_pkg::B_HI_EN];
    assign irq_req_sixth    = s.fixed_ctrl[eirq_pkg::B_LO_FLAG] & s.fixed_ctrl[eirq_pkg::B_LO_EN];
    assign irq_req_seventh  = s.fixed_ctrl[eirq_pkg::B_HI_FLAG] & s.fixed_ctrl[eirq_pkg::B_HI_EN];
    assign hold_release     = irq_req_low_sel | irq_req_high_sel;

    assign port_two_out  = s.p2_out;
    assign port_two_oe_n = s.p2_oe_n;
    assign second_timer_low_count      = s.cnt_pulse;
    assign second_timer_low_event_mode = (lo_func == eirq_pkg::FUNC_COUNT) | (hi_func == eirq_pkg::FUNC_COUNT);
    assign first_timer_low_capture     = s.cap_lo;
    assign first_timer_high_capture    = s.cap_hi;
    assign first_timer_low_capture1    = s.cap1_lo;
    assign first_timer_high_capture1   = s.cap1_hi;
endmodule

// ### verif/eirq_pin_source.sv
`timescale 1ns/1ps
module eirq_pin_source (
    input  wire logic       aclk,
    input  wire logic [7:0] port_two_out,
    input  wire logic [7:0] port_two_oe_n,
    output logic      [7:0] port_two_in
);
    logic [7:0] level = 8'h00;
    // Enabled bits show the block's drive, the rest the source.
    assign port_two_in = (port_two_out & ~port_two_oe_n) | (level & port_two_oe_n);
    // Levels change just after an edge.
    task automatic set(input logic [7:0] m, input logic v);
        @(posedge aclk);
        level <= v ? (level | m) : (level & ~m);
    endtask
    // An n-cycle high pulse: one rise, one fall.
    task automatic pulse(input logic [7:0] m, input int n);
        set(m, 1'b1);
        repeat (n - 1) @(posedge aclk);
        set(m, 1'b0);
    endtask
endmodule

// ### verif/eirq_router_monitor.sv
`timescale 1ns/1ps
module eirq_router_monitor #(
    parameter int CLKS_PER_TCYC = 3
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [7:0] port_two_in,
    input wire logic [7:0] port_two_out,
    input wire logic [7:0] port_two_oe_n,
    input wire logic       halt_mode,
    input wire logic       hold_mode,
    input wire logic       s_axi_bvalid,
    input wire logic       irq_req_low_sel,
    input wire logic       irq_req_high_sel,
    input wire logic       irq_req_sixth,
    input wire logic       irq_req_seventh,
    input wire logic       hold_release,
    input wire logic       second_timer_low_count,
    input wire logic       second_timer_low_event_mode,
    input wire logic       first_timer_low_capture1,
    input wire logic       first_timer_high_capture1
);
    logic [7:0] gap;
    logic       gap_ok;
    logic       lp_any;
    default clocking mon_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    assign lp_any = halt_mode | hold_mode;
    // Gap between free-run ticks; event-mode ticks follow pins.
    always_ff @(posedge aclk) begin
        if (!aresetn || second_timer_low_event_mode) begin
            gap    <= 8'h00;
            gap_ok <= 1'b0;
        end else if (second_timer_low_count) begin
            gap    <= 8'h00;
            gap_ok <= 1'b1;
        end else begin
            gap    <= gap + 8'h01;
            gap_ok <= gap_ok;
        end
    end
    // Capture1 lags its pin change by two samples.
    sequence s_edge_sixth;
        $past(port_two_in[0], 2) != $past(port_two_in[0], 3);
    endsequence
    sequence s_edge_seventh;
        $past(port_two_in[4], 2) != $past(port_two_in[4], 3);
    endsequence
    sequence s_write_done;
        $rose(s_axi_bvalid);
    endsequence
    AST_HOLD_RELEASE: assert property (hold_release == (irq_req_low_sel || irq_req_high_sel))
        else $error("Hold release mismatch.");
    AST_SIXTH_CAP_CAUSE: assert property (first_timer_low_capture1 |-> s_edge_sixth)
        else $error("Low capture1 without edge.");
    AST_SEVENTH_CAP_CAUSE: assert property (first_timer_high_capture1 |-> s_edge_seventh)
        else $error("High capture1 without edge.");
    AST_SIXTH_STICKY: assert property ($fell(irq_req_sixth) |-> s_write_done)
        else $error("Sixth flag dropped unwritten.");
    AST_SEVENTH_STICKY: assert property ($fell(irq_req_seventh) |-> s_write_done)
        else $error("Seventh flag dropped unwritten.");
    AST_SEL_STICKY: assert property ($fell(irq_req_low_sel) || $fell(irq_req_high_sel) |-> s_write_done)
        else $error("Selectable flag dropped unwritten.");
    AST_FREE_PERIOD: assert property (second_timer_low_count && gap_ok && !second_timer_low_event_mode
        |-> gap == 8'(2 * CLKS_PER_TCYC - 1))
        else $error("Free-run period wrong.");
    AST_PORT_FROZEN: assert property (lp_any && $past(lp_any) |=> $stable(port_two_out) && $stable(port_two_oe_n))
        else $error("Port two moved in low power.");
endmodule
bind eirq_router eirq_router_monitor #(.CLKS_PER_TCYC(CLKS_PER_TCYC)) eirq_router_monitor_inst (
    .aclk(aclk), .aresetn(aresetn), .port_two_in(port_two_in), .port_two_out(port_two_out),
    .port_two_oe_n(port_two_oe_n), .halt_mode(halt_mode), .hold_mode(hold_mode), .s_axi_bvalid(s_axi_bvalid),
    .irq_req_low_sel(irq_req_low_sel), .irq_req_high_sel(irq_req_high_sel), .irq_req_sixth(irq_req_sixth),
    .irq_req_seventh(irq_req_seventh), .hold_release(hold_release),
    .second_timer_low_count(second_timer_low_count), .second_timer_low_event_mode(second_timer_low_event_mode),
    .first_timer_low_capture1(first_timer_low_capture1), .first_timer_high_capture1(first_timer_high_capture1)
);

// ### verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("ERROR at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, halt_mode = 1'b0, hold_mode = 1'b0;
    logic        port_seven_cap_lo = 1'b0, port_seven_cap_hi = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, m, f;
    logic [7:0]  port_two_in, port_two_out, port_two_oe_n;
    logic        irq_req_low_sel, irq_req_high_sel, irq_req_sixth, irq_req_seventh, hold_release;
    logic        second_timer_low_count, second_timer_low_event_mode, first_timer_low_capture;
    logic        first_timer_high_capture, first_timer_low_capture1, first_timer_high_capture1;
    int          n_fail = 0, compares = 0, cnt [5];
    // One clock per instruction cycle keeps runs short.
    eirq_router #(.CLKS_PER_TCYC(1)) eirq_router_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_two_in, .port_two_out, .port_two_oe_n, .halt_mode, .hold_mode,
        .port_seven_cap_lo, .port_seven_cap_hi, .irq_req_low_sel, .irq_req_high_sel, .irq_req_sixth,
        .irq_req_seventh, .hold_release, .second_timer_low_count, .second_timer_low_event_mode,
        .first_timer_low_capture, .first_timer_high_capture, .first_timer_low_capture1, .first_timer_high_capture1
    );
    eirq_pin_source src_inst (.aclk, .port_two_out, .port_two_oe_n, .port_two_in);
    always #2.5 aclk = ~aclk;
    // Pulse counters, cleared between edges.
    always @(posedge aclk) begin
        if (first_timer_low_capture) cnt[0] <= cnt[0] + 1;
        if (first_timer_high_capture) cnt[1] <= cnt[1] + 1;
        if (second_timer_low_count) cnt[2] <= cnt[2] + 1;
        if (first_timer_low_capture1) cnt[3] <= cnt[3] + 1;
        if (first_timer_high_capture1) cnt[4] <= cnt[4] + 1;
    end
    task automatic clr;
        @(negedge aclk);
        cnt = '{default: 0};
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Address and data offered together; each dropped once taken.
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er = eirq_pkg::RESP_OKAY);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'(d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        if (i == 40) begin n_fail++; tally_and_finish(); end
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er = eirq_pkg::RESP_OKAY);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, 32'(d))
        `CHK(s_axi_rresp, er)
        if (i == 40) begin n_fail++; tally_and_finish(); end
    endtask
    initial begin
        tick(6);
        aresetn <= 1'b1;
        // Registers clear to zero; unmapped addresses are refused.
        rd(eirq_pkg::ADDR_P2_DATA, 8'h00);
        rd(eirq_pkg::ADDR_P2_DIR, 8'h00);
        rd(eirq_pkg::ADDR_SEL_CTRL, 8'h00);
        rd(eirq_pkg::ADDR_ROUTING, 8'h00);
        rd(eirq_pkg::ADDR_FIXED, 8'h00);
        wr(32'h00000010, 8'hff, eirq_pkg::RESP_SLVERR);
        rd(32'h00000010, 8'h00, eirq_pkg::RESP_SLVERR);
        // Halt freezes the port drive.
        wr(eirq_pkg::ADDR_P2_DIR, 8'hff);
        wr(eirq_pkg::ADDR_P2_DATA, 8'h5a);
        tick(2);
        `CHK(port_two_oe_n, 8'h00)
        rd(eirq_pkg::ADDR_P2_DATA, 8'h5a);
        halt_mode <= 1'b1;
        wr(eirq_pkg::ADDR_P2_DATA, 8'ha5);
        tick(3);
        `CHK(port_two_out, 8'h5a)
        halt_mode <= 1'b0;
        tick(3);
        `CHK(port_two_out, 8'ha5)
        wr(eirq_pkg::ADDR_P2_DIR, 8'h00);
        // Each fixed-pair edge mode: rise then fall.
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr(eirq_pkg::ADDR_FIXED, {m, 2'b01, m, 2'b01});
            clr();
            src_inst.set(8'h11, 1'b1);
            tick(5);
            `CHK(irq_req_sixth, m[1])
            `CHK(irq_req_seventh, m[1])
            rd(eirq_pkg::ADDR_FIXED, {m, m[1], 1'b1, m, m[1], 1'b1});
            wr(eirq_pkg::ADDR_FIXED, {m, 2'b01, m, 2'b01});
            src_inst.set(8'h11, 1'b0);
            tick(5);
            `CHK(irq_req_sixth, m[0])
            `CHK(cnt[3], int'(m[0]) + int'(m[1]))
            `CHK(cnt[4], int'(m[0]) + int'(m[1]))
        end
        wr(eirq_pkg::ADDR_FIXED, 8'h00);
        // Every pin choice of both selectables, both edges.
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr(eirq_pkg::ADDR_ROUTING, {m, 2'b00, m, 2'b00});
            wr(eirq_pkg::ADDR_SEL_CTRL, 8'hdd);
            src_inst.pulse(8'h01 << m, 3);
            tick(4);
            `CHK(irq_req_low_sel, 1'b1)
            `CHK(irq_req_high_sel, 1'b0)
            `CHK(hold_release, 1'b1)
            wr(eirq_pkg::ADDR_SEL_CTRL, 8'hdd);
            src_inst.pulse(8'h10 << m, 3);
            tick(4);
            `CHK(irq_req_high_sel, 1'b1)
            rd(eirq_pkg::ADDR_SEL_CTRL, 8'hfd);
        end
        // Each function code on both selectables, simultaneous edges.
        for (int k = 0; k < 4; k++) begin
            f = k[1:0];
            wr(eirq_pkg::ADDR_ROUTING, {2'h0, f, 2'h0, f});
            wr(eirq_pkg::ADDR_SEL_CTRL, 8'h88);
            `CHK(second_timer_low_event_mode, f == 2'h1)
            clr();
            src_inst.set(8'h11, 1'b1);
            tick(4);
            `CHK(cnt[0], int'(f == 2'h2))
            `CHK(cnt[1], int'(f == 2'h3))
            if (f == 2'h1) `CHK(cnt[2], 1)
            clr();
            port_seven_cap_lo <= 1'b1;
            port_seven_cap_hi <= 1'b1;
            tick(1);
            port_seven_cap_lo <= 1'b0;
            port_seven_cap_hi <= 1'b0;
            tick(3);
            `CHK(cnt[0], int'(f != 2'h2))
            `CHK(cnt[1], int'(f != 2'h3))
            src_inst.set(8'h11, 1'b0);
        end
        // In hold a rise toward the entry level is blocked.
        wr(eirq_pkg::ADDR_ROUTING, 8'h00);
        src_inst.set(8'h01, 1'b1);
        wr(eirq_pkg::ADDR_SEL_CTRL, 8'h09);
        hold_mode <= 1'b1;
        src_inst.pulse(8'h01, 3);
        src_inst.set(8'h01, 1'b1);
        tick(4);
        `CHK(irq_req_low_sel, 1'b0)
        hold_mode <= 1'b0;
        src_inst.set(8'h01, 1'b0);
        src_inst.set(8'h01, 1'b1);
        tick(4);
        `CHK(irq_req_low_sel, 1'b1)
        tally_and_finish();
    end
endmodule
